//--- hw/rsem_pkg.sv
// Constants, code layout and register map of the SECDED memory block
// Behaviour
// - Decode-only mode stores the supplied 72-bit word unchanged, bad bits included.
// - Single-bit error on read: corrected word out, single_error_flag set with it.
// - Double-bit error on read: word left as stored, double_error_flag set with it.
// - Encode-only mode computes the eight check bits internally for each written word.
// - Fresh check value shown on check_bits_out after write with encoder on; reads return 72 bits.
// - check_bits_out changes on the write clock edge that stored the word.
// - single_error_flag changes on read clock, direct or through output register.
// - double_error_flag changes on read clock, direct or through output register.
// - Read data and check bits come from latch or extra register, as configured.
// - Decode-only mode takes check bits from write_check_in instead of the encoder.
// - Encode-only reads are plain reads: no correction, both flags low.
// - Output register mode delays data, check and flags one read edge, aligned.
// - Decoder and encoder have independent enables; standard mode sets both.
package rsem_pkg;
	// Memory and code geometry
	localparam int unsigned DATA_W      = 64;
	localparam int unsigned CHK_W       = 8;
	localparam int unsigned HAM_W       = 7;
	localparam int unsigned WORD_W      = 72;
	localparam int unsigned ADDR_W      = 9;
	localparam int unsigned DEPTH       = 512;
	localparam int unsigned MAX_POS     = 71;
	// Synchronised write pins: clock, enable, address, data, check
	localparam int unsigned WB_CHK_LSB  = 0;
	localparam int unsigned WB_DATA_LSB = 8;
	localparam int unsigned WB_ADDR_LSB = 72;
	localparam int unsigned WB_EN_BIT   = 81;
	localparam int unsigned WB_CLK_BIT  = 82;
	localparam int unsigned WB_W        = 83;
	// Synchronised read pins: clock, enable, address
	localparam int unsigned RB_ADDR_LSB = 0;
	localparam int unsigned RB_EN_BIT   = 9;
	localparam int unsigned RB_CLK_BIT  = 10;
	localparam int unsigned RB_W        = 11;
	// Read word with flags: data, check, double, single
	localparam int unsigned PK_DED_BIT  = 72;
	localparam int unsigned PK_SEC_BIT  = 73;
	localparam int unsigned PK_W        = 74;
	// APB register map
	localparam int unsigned APB_AW      = 12;
	localparam int unsigned APB_DW      = 32;
	localparam logic [11:0] CTRL_OFF    = 12'h000;
	localparam logic [11:0] STATUS_OFF  = 12'h004;
	localparam logic [11:0] CLEAR_OFF   = 12'h008;
	localparam logic [11:0] ENABLE_OFF  = 12'h00C;
	localparam logic [11:0] EADDR_OFF   = 12'h010;
	localparam logic [11:0] SECCNT_OFF  = 12'h014;
	localparam logic [11:0] DEDCNT_OFF  = 12'h018;
	localparam logic [11:0] LASTCHK_OFF = 12'h01C;
	// Control fields and reset value (standard mode, latch output)
	localparam int unsigned CTRL_ENC_BIT  = 0;
	localparam int unsigned CTRL_DEC_BIT  = 1;
	localparam int unsigned CTRL_OREG_BIT = 2;
	localparam int unsigned CTRL_W        = 3;
	localparam logic [2:0]  CTRL_RESET    = 3'h3;
	// Event bits of status, clear and enable
	localparam int unsigned EV_SEC_BIT  = 0;
	localparam int unsigned EV_DED_BIT  = 1;
	localparam int unsigned EV_W        = 2;
	localparam int unsigned COUNT_W     = 16;
	localparam logic [15:0] COUNT_MAX   = 16'hFFFF;
endpackage

//--- hw/rsem_code_if.sv
// Link between the memory core and the SECDED codec
`timescale 1ns/1ps
interface rsem_code_if;
	logic [rsem_pkg::DATA_W-1:0] enc_data;
	logic [rsem_pkg::CHK_W-1:0]  enc_check;
	logic                        dec_enable;
	logic [rsem_pkg::WORD_W-1:0] dec_word;
	logic [rsem_pkg::DATA_W-1:0] dec_data;
	logic [rsem_pkg::CHK_W-1:0]  dec_check;
	logic                        dec_single;
	logic                        dec_double;

	modport core
	(
		output enc_data,
		output dec_enable,
		output dec_word,
		input  enc_check,
		input  dec_data,
		input  dec_check,
		input  dec_single,
		input  dec_double
	);

	modport codec
	(
		input  enc_data,
		input  dec_enable,
		input  dec_word,
		output enc_check,
		output dec_data,
		output dec_check,
		output dec_single,
		output dec_double
	);
endinterface

//--- hw/rsem_codec.sv
// SECDED check-bit encoder and correcting decoder
`timescale 1ns/1ps
module rsem_codec
(
	// Codec side of the core link
	rsem_code_if.codec cif
);
	// Code position of a data bit, skipping power-of-two check slots
	function automatic logic [rsem_pkg::HAM_W-1:0] data_pos(input int unsigned idx);
		int unsigned n;
		logic [rsem_pkg::HAM_W-1:0] p;
		n = 0;
		p = 7'h00;
		for (int unsigned k = 3; k <= rsem_pkg::MAX_POS; k++)
		begin
			if ((k & (k - 1)) != 0)
			begin
				if (n == idx)
					p = 7'(k);
				n++;
			end
		end
		return p;
	endfunction

	// Hamming bits are the XOR of positions of all set data bits
	function automatic logic [rsem_pkg::HAM_W-1:0] ham_bits(input logic [63:0] d);
		logic [rsem_pkg::HAM_W-1:0] h;
		h = 7'h00;
		for (int unsigned i = 0; i < rsem_pkg::DATA_W; i++)
		begin
			if (d[i])
				h = h ^ data_pos(i);
		end
		return h;
	endfunction

	logic [rsem_pkg::HAM_W-1:0]  enc_ham;
	logic [rsem_pkg::DATA_W-1:0] raw_data;
	logic [rsem_pkg::CHK_W-1:0]  raw_chk;
	logic [rsem_pkg::HAM_W-1:0]  syn;
	logic                        odd;
	logic [rsem_pkg::DATA_W-1:0] data_flip;
	logic [rsem_pkg::CHK_W-1:0]  chk_flip;

	assign enc_ham       = ham_bits(cif.enc_data);
	assign cif.enc_check = {^{cif.enc_data, enc_ham}, enc_ham};
	assign raw_data      = cif.dec_word[rsem_pkg::DATA_W-1:0];
	assign raw_chk       = cif.dec_word[rsem_pkg::WORD_W-1:rsem_pkg::DATA_W];
	assign syn           = ham_bits(raw_data) ^ raw_chk[rsem_pkg::HAM_W-1:0];
	assign odd           = ^cif.dec_word;

	always_comb
	begin
		for (int unsigned i = 0; i < rsem_pkg::DATA_W; i++)
			data_flip[i] = (data_pos(i) == syn);
		// Zero syndrome with odd weight points at the overall parity bit
		chk_flip[rsem_pkg::CHK_W-1] = (syn == 7'h00);
		for (int unsigned j = 0; j < rsem_pkg::HAM_W; j++)
			chk_flip[j] = (32'(syn) == (32'h1 << j));
	end

	always_comb
	begin
		cif.dec_data   = raw_data;
		cif.dec_check  = raw_chk;
		cif.dec_single = 1'b0;
		cif.dec_double = 1'b0;
		if (cif.dec_enable)
		begin
			if (odd && (32'(syn) > rsem_pkg::MAX_POS))
				cif.dec_double = 1'b1;
			else if (odd)
			begin
				cif.dec_single = 1'b1;
				cif.dec_data   = raw_data ^ data_flip;
				cif.dec_check  = raw_chk ^ chk_flip;
			end
			else if (syn != 7'h00)
				cif.dec_double = 1'b1;
		end
	end
endmodule

//--- hw/rsem_top.sv
// Dual-port 512x72 memory with SECDED encode, decode and APB control
`timescale 1ns/1ps
module rsem_top
(
	// Clock and reset
	input  wire logic                          CORE_CLK,
	input  wire logic                          ARST_N,
	// APB slave
	input  wire logic                          PSEL,
	input  wire logic                          PENABLE,
	input  wire logic                          PWRITE,
	input  wire logic [rsem_pkg::APB_AW-1:0]   PADDR,
	input  wire logic [rsem_pkg::APB_DW-1:0]   PWDATA,
	output logic                               PREADY,
	output logic [rsem_pkg::APB_DW-1:0]        PRDATA,
	output logic                               PSLVERR,
	// Write port pins
	input  wire logic                          WRITE_CLOCK,
	input  wire logic                          WRITE_ENABLE,
	input  wire logic [rsem_pkg::ADDR_W-1:0]   WRITE_ADDR,
	input  wire logic [rsem_pkg::DATA_W-1:0]   WRITE_DATA_IN,
	input  wire logic [rsem_pkg::CHK_W-1:0]    WRITE_CHECK_IN,
	output logic [rsem_pkg::CHK_W-1:0]         CHECK_BITS_OUT,
	// Read port pins
	input  wire logic                          READ_CLOCK,
	input  wire logic                          READ_ENABLE,
	input  wire logic [rsem_pkg::ADDR_W-1:0]   READ_ADDR,
	output logic [rsem_pkg::DATA_W-1:0]        READ_DATA_OUT,
	output logic [rsem_pkg::CHK_W-1:0]         READ_CHECK_OUT,
	output logic                               SINGLE_ERROR_FLAG,
	output logic                               DOUBLE_ERROR_FLAG,
	// Interrupt
	output logic                               IRQ
);
	// Saturating event counter step
	function automatic logic [15:0] sat_inc(input logic [15:0] c, input logic inc);
		logic [15:0] r;
		r = c;
		if (inc && (c != rsem_pkg::COUNT_MAX))
			r = 16'(c + 16'h0001);
		return r;
	endfunction

	// Storage
	logic [rsem_pkg::WORD_W-1:0]  mem [0:rsem_pkg::DEPTH-1];

	// Pin synchronisers
	logic [rsem_pkg::WB_W-1:0]    wr_pins;
	logic [rsem_pkg::WB_W-1:0]    wr_meta_q;
	logic [rsem_pkg::WB_W-1:0]    wr_sync_q;
	logic                         wr_clk_last_q;
	logic [rsem_pkg::RB_W-1:0]    rd_pins;
	logic [rsem_pkg::RB_W-1:0]    rd_meta_q;
	logic [rsem_pkg::RB_W-1:0]    rd_sync_q;
	logic                         rd_clk_last_q;

	// Write side
	logic                         wr_edge;
	logic                         wr_go;
	logic [rsem_pkg::ADDR_W-1:0]  wr_addr_s;
	logic [rsem_pkg::DATA_W-1:0]  wr_data_s;
	logic [rsem_pkg::CHK_W-1:0]   wr_check_s;
	logic [rsem_pkg::CHK_W-1:0]   wr_store_check;
	logic [rsem_pkg::CHK_W-1:0]   check_bits_q;

	// Read side
	logic                         rd_edge;
	logic                         rd_go;
	logic [rsem_pkg::ADDR_W-1:0]  rd_addr_s;
	logic [rsem_pkg::PK_W-1:0]    dec_pack;
	logic [rsem_pkg::PK_W-1:0]    pipe_q;
	logic [rsem_pkg::ADDR_W-1:0]  pipe_addr_q;
	logic [rsem_pkg::PK_W-1:0]    out_q;
	logic                         out_load;
	logic [rsem_pkg::PK_W-1:0]    out_next;
	logic [rsem_pkg::ADDR_W-1:0]  out_addr;

	// Control and status
	logic [rsem_pkg::CTRL_W-1:0]  ctrl_q;
	logic                         ctrl_enc;
	logic                         ctrl_dec;
	logic                         ctrl_oreg;
	logic [rsem_pkg::EV_W-1:0]    events;
	logic [rsem_pkg::EV_W-1:0]    status_q;
	logic [rsem_pkg::EV_W-1:0]    status_d;
	logic [rsem_pkg::EV_W-1:0]    clr_mask;
	logic [rsem_pkg::EV_W-1:0]    int_en_q;
	logic [rsem_pkg::EV_W-1:0]    int_en_d;
	logic                         irq_q;
	logic [rsem_pkg::ADDR_W-1:0]  err_addr_q;
	logic [rsem_pkg::COUNT_W-1:0] sec_cnt_q;
	logic [rsem_pkg::COUNT_W-1:0] ded_cnt_q;
	logic [rsem_pkg::COUNT_W-1:0] sec_cnt_d;
	logic [rsem_pkg::COUNT_W-1:0] ded_cnt_d;

	// APB slave
	logic                         apb_setup;
	logic                         apb_wr;
	logic                         hit_ctrl;
	logic                         hit_status;
	logic                         hit_clear;
	logic                         hit_enable;
	logic                         hit_eaddr;
	logic                         hit_sec;
	logic                         hit_ded;
	logic                         hit_last;
	logic [rsem_pkg::APB_DW-1:0]  rd_val;
	logic                         rd_hit;
	logic                         pready_q;
	logic [rsem_pkg::APB_DW-1:0]  prdata_q;
	logic                         pslverr_q;

	rsem_code_if cif ();

	rsem_codec u_codec
	(
		.cif (cif.codec)
	);

	// Every write and read port pin crosses two flops; clock pins move with their data
	assign wr_pins = {WRITE_CLOCK, WRITE_ENABLE, WRITE_ADDR, WRITE_DATA_IN, WRITE_CHECK_IN};
	assign rd_pins = {READ_CLOCK, READ_ENABLE, READ_ADDR};

	always_ff @(posedge CORE_CLK or negedge ARST_N)
	begin
		if (!ARST_N)
		begin
			wr_meta_q     <= '0;
			wr_sync_q     <= '0;
			wr_clk_last_q <= 1'b0;
			rd_meta_q     <= '0;
			rd_sync_q     <= '0;
			rd_clk_last_q <= 1'b0;
		end
		else
		begin
			wr_meta_q     <= wr_pins;
			wr_sync_q     <= wr_meta_q;
			wr_clk_last_q <= wr_sync_q[rsem_pkg::WB_CLK_BIT];
			rd_meta_q     <= rd_pins;
			rd_sync_q     <= rd_meta_q;
			rd_clk_last_q <= rd_sync_q[rsem_pkg::RB_CLK_BIT];
		end
	end

	assign wr_edge    = wr_sync_q[rsem_pkg::WB_CLK_BIT] & ~wr_clk_last_q;
	assign wr_go      = wr_edge & wr_sync_q[rsem_pkg::WB_EN_BIT];
	assign wr_addr_s  = wr_sync_q[rsem_pkg::WB_ADDR_LSB +: rsem_pkg::ADDR_W];
	assign wr_data_s  = wr_sync_q[rsem_pkg::WB_DATA_LSB +: rsem_pkg::DATA_W];
	assign wr_check_s = wr_sync_q[rsem_pkg::WB_CHK_LSB +: rsem_pkg::CHK_W];
	assign rd_edge    = rd_sync_q[rsem_pkg::RB_CLK_BIT] & ~rd_clk_last_q;
	assign rd_go      = rd_edge & rd_sync_q[rsem_pkg::RB_EN_BIT];
	assign rd_addr_s  = rd_sync_q[rsem_pkg::RB_ADDR_LSB +: rsem_pkg::ADDR_W];

	// Mode bits
	assign ctrl_enc  = ctrl_q[rsem_pkg::CTRL_ENC_BIT];
	assign ctrl_dec  = ctrl_q[rsem_pkg::CTRL_DEC_BIT];
	assign ctrl_oreg = ctrl_q[rsem_pkg::CTRL_OREG_BIT];

	// Write path: encoder check bits or the supplied ones
	assign cif.enc_data   = wr_data_s;
	assign wr_store_check = ctrl_enc ? cif.enc_check : wr_check_s;

	// Array has no reset; contents are undefined until written
	always_ff @(posedge CORE_CLK)
	begin
		if (wr_go)
			mem[wr_addr_s] <= {wr_store_check, wr_data_s};
	end

	always_ff @(posedge CORE_CLK or negedge ARST_N)
	begin
		if (!ARST_N)
			check_bits_q <= 8'h00;
		else if (wr_go && ctrl_enc)
			check_bits_q <= cif.enc_check;
	end

	// Read path: old contents when read and write hit one address at once
	assign cif.dec_word   = mem[rd_addr_s];
	assign cif.dec_enable = ctrl_dec;
	assign dec_pack = {cif.dec_single, cif.dec_double, cif.dec_check, cif.dec_data};

	// Latch mode loads on enabled reads; register mode on every read edge
	assign out_load = ctrl_oreg ? rd_edge : rd_go;
	assign out_next = ctrl_oreg ? pipe_q : dec_pack;
	assign out_addr = ctrl_oreg ? pipe_addr_q : rd_addr_s;

	always_ff @(posedge CORE_CLK or negedge ARST_N)
	begin
		if (!ARST_N)
		begin
			pipe_q      <= '0;
			pipe_addr_q <= 9'h000;
		end
		else if (rd_go)
		begin
			pipe_q      <= dec_pack;
			pipe_addr_q <= rd_addr_s;
		end
	end

	// Flags travel with their word, so a clean word clears them
	always_ff @(posedge CORE_CLK or negedge ARST_N)
	begin
		if (!ARST_N)
			out_q <= '0;
		else if (out_load)
			out_q <= out_next;
	end

	// Error events seen as the flagged word reaches the pins
	assign events[rsem_pkg::EV_SEC_BIT] = out_load & out_next[rsem_pkg::PK_SEC_BIT];
	assign events[rsem_pkg::EV_DED_BIT] = out_load & out_next[rsem_pkg::PK_DED_BIT];

	// APB decode
	assign apb_setup  = PSEL & ~PENABLE;
	assign apb_wr     = PSEL & PENABLE & PWRITE & pready_q;
	assign hit_ctrl   = (PADDR == rsem_pkg::CTRL_OFF);
	assign hit_status = (PADDR == rsem_pkg::STATUS_OFF);
	assign hit_clear  = (PADDR == rsem_pkg::CLEAR_OFF);
	assign hit_enable = (PADDR == rsem_pkg::ENABLE_OFF);
	assign hit_eaddr  = (PADDR == rsem_pkg::EADDR_OFF);
	assign hit_sec    = (PADDR == rsem_pkg::SECCNT_OFF);
	assign hit_ded    = (PADDR == rsem_pkg::DEDCNT_OFF);
	assign hit_last   = (PADDR == rsem_pkg::LASTCHK_OFF);

	always_comb
	begin
		rd_val = 32'h0000_0000;
		rd_hit = 1'b1;
		if (hit_ctrl)
			rd_val = 32'(ctrl_q);
		else if (hit_status)
			rd_val = 32'(status_q);
		else if (hit_clear)
			rd_val = 32'h0000_0000;
		else if (hit_enable)
			rd_val = 32'(int_en_q);
		else if (hit_eaddr)
			rd_val = 32'(err_addr_q);
		else if (hit_sec)
			rd_val = 32'(sec_cnt_q);
		else if (hit_ded)
			rd_val = 32'(ded_cnt_q);
		else if (hit_last)
			rd_val = 32'(check_bits_q);
		else
			rd_hit = 1'b0;
	end

	// Sticky status: a new event wins over a clear in the same cycle
	assign clr_mask  = (apb_wr && hit_clear) ? PWDATA[rsem_pkg::EV_W-1:0] : 2'h0;
	assign status_d  = (status_q & ~clr_mask) | events;
	assign int_en_d  = (apb_wr && hit_enable) ? PWDATA[rsem_pkg::EV_W-1:0] : int_en_q;
	assign sec_cnt_d = sat_inc((apb_wr && hit_sec) ? 16'h0000 : sec_cnt_q,
		events[rsem_pkg::EV_SEC_BIT]);
	assign ded_cnt_d = sat_inc((apb_wr && hit_ded) ? 16'h0000 : ded_cnt_q,
		events[rsem_pkg::EV_DED_BIT]);

	always_ff @(posedge CORE_CLK or negedge ARST_N)
	begin
		if (!ARST_N)
		begin
			ctrl_q     <= rsem_pkg::CTRL_RESET;
			status_q   <= 2'h0;
			int_en_q   <= 2'h0;
			irq_q      <= 1'b0;
			err_addr_q <= 9'h000;
			sec_cnt_q  <= 16'h0000;
			ded_cnt_q  <= 16'h0000;
		end
		else
		begin
			if (apb_wr && hit_ctrl)
				ctrl_q <= PWDATA[rsem_pkg::CTRL_W-1:0];
			status_q  <= status_d;
			int_en_q  <= int_en_d;
			irq_q     <= |(status_d & int_en_d);
			sec_cnt_q <= sec_cnt_d;
			ded_cnt_q <= ded_cnt_d;
			if (|events)
				err_addr_q <= out_addr;
		end
	end

	// Zero-wait slave: ready in the access cycle after every setup
	always_ff @(posedge CORE_CLK or negedge ARST_N)
	begin
		if (!ARST_N)
		begin
			pready_q  <= 1'b0;
			prdata_q  <= 32'h0000_0000;
			pslverr_q <= 1'b0;
		end
		else
		begin
			pready_q  <= apb_setup;
			pslverr_q <= apb_setup & ~rd_hit;
			if (apb_setup)
				prdata_q <= rd_val;
		end
	end

	// Outputs
	assign PREADY            = pready_q;
	assign PRDATA            = prdata_q;
	assign PSLVERR           = pslverr_q;
	assign IRQ               = irq_q;
	assign CHECK_BITS_OUT    = check_bits_q;
	assign READ_DATA_OUT     = out_q[rsem_pkg::DATA_W-1:0];
	assign READ_CHECK_OUT    = out_q[rsem_pkg::WORD_W-1:rsem_pkg::DATA_W];
	assign SINGLE_ERROR_FLAG = out_q[rsem_pkg::PK_SEC_BIT];
	assign DOUBLE_ERROR_FLAG = out_q[rsem_pkg::PK_DED_BIT];
endmodule

//--- tb/rsem_top_sva.sv
// Port-level assertions for the SECDED memory block
`timescale 1ns/1ps
module rsem_top_sva
(
	// Clock and reset
	input wire logic                        CORE_CLK,
	input wire logic                        ARST_N,
	// APB
	input wire logic                        PSEL,
	input wire logic                        PENABLE,
	input wire logic                        PWRITE,
	input wire logic [rsem_pkg::APB_AW-1:0] PADDR,
	input wire logic [rsem_pkg::APB_DW-1:0] PWDATA,
	input wire logic                        PREADY,
	// Memory pins
	input wire logic                        WRITE_CLOCK,
	input wire logic                        WRITE_ENABLE,
	input wire logic [rsem_pkg::CHK_W-1:0]  CHECK_BITS_OUT,
	input wire logic                        READ_CLOCK,
	input wire logic                        READ_ENABLE,
	input wire logic [rsem_pkg::DATA_W-1:0] READ_DATA_OUT,
	input wire logic [rsem_pkg::CHK_W-1:0]  READ_CHECK_OUT,
	input wire logic                        SINGLE_ERROR_FLAG,
	input wire logic                        DOUBLE_ERROR_FLAG,
	input wire logic                        IRQ
);
	wire logic  ctrl_wr;
	logic [2:0] ctrl_q;

	assign ctrl_wr = PSEL && PENABLE && PWRITE && PREADY && (PADDR == rsem_pkg::CTRL_OFF);

	// Shadow of the mode register
	always_ff @(posedge CORE_CLK or negedge ARST_N)
		if (!ARST_N)
			ctrl_q <= rsem_pkg::CTRL_RESET;
		else if (ctrl_wr)
			ctrl_q <= PWDATA[2:0];

	default clocking cb @(posedge CORE_CLK); endclocking
	default disable iff (!ARST_N);

	AST_CHK_AFTER_WRITE: assert property ($changed(CHECK_BITS_OUT) |-> $past(WRITE_CLOCK, 3)
		&& !$past(WRITE_CLOCK, 4) && $past(WRITE_ENABLE, 3))
		else $error("check bits moved without a write");
	AST_CHK_ENC_ON: assert property ($changed(CHECK_BITS_OUT) |-> $past(ctrl_q[0], 1))
		else $error("check bits moved with encoder off");
	AST_SEC_ON_READ: assert property ($changed(SINGLE_ERROR_FLAG) |-> $past(READ_CLOCK, 3)
		&& !$past(READ_CLOCK, 4))
		else $error("single flag moved outside a read");
	AST_DED_ON_READ: assert property ($changed(DOUBLE_ERROR_FLAG) |-> $past(READ_CLOCK, 3)
		&& !$past(READ_CLOCK, 4))
		else $error("double flag moved outside a read");
	AST_DATA_ON_READ: assert property ($changed({READ_CHECK_OUT, READ_DATA_OUT}) |->
		$past(READ_CLOCK, 3) && !$past(READ_CLOCK, 4) && ($past(READ_ENABLE, 3) || ctrl_q[2]))
		else $error("read word moved outside an enabled read");
	AST_FLAGS_EXCL: assert property (SINGLE_ERROR_FLAG |-> !DOUBLE_ERROR_FLAG)
		else $error("both error flags high");
	AST_ENC_ONLY_QUIET: assert property ($rose(SINGLE_ERROR_FLAG) || $rose(DOUBLE_ERROR_FLAG)
		|-> $past(ctrl_q[1], 1))
		else $error("error flag raised with decoder off");
	AST_APB_READY: assert property (PSEL && !PENABLE |=> PREADY ##1 !PREADY)
		else $error("ready not a one-cycle pulse after setup");

	cover property ($rose(SINGLE_ERROR_FLAG));
	cover property ($rose(DOUBLE_ERROR_FLAG));
	cover property ($rose(IRQ));
endmodule

bind rsem_top rsem_top_sva u_sva (.CORE_CLK(CORE_CLK), .ARST_N(ARST_N), .PSEL(PSEL),
	.PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PREADY(PREADY),
	.WRITE_CLOCK(WRITE_CLOCK), .WRITE_ENABLE(WRITE_ENABLE), .CHECK_BITS_OUT(CHECK_BITS_OUT),
	.READ_CLOCK(READ_CLOCK), .READ_ENABLE(READ_ENABLE), .READ_DATA_OUT(READ_DATA_OUT),
	.READ_CHECK_OUT(READ_CHECK_OUT), .SINGLE_ERROR_FLAG(SINGLE_ERROR_FLAG),
	.DOUBLE_ERROR_FLAG(DOUBLE_ERROR_FLAG), .IRQ(IRQ));

//--- tb/rsem_user_model.sv
// User logic model driving the memory write and read pins
`timescale 1ns/1ps
module rsem_user_model
(
	// Core clock
	input  wire logic                        clk,
	// Write port
	output logic                             wr_clk,
	output logic                             wr_en,
	output logic [rsem_pkg::ADDR_W-1:0]      wr_addr,
	output logic [rsem_pkg::DATA_W-1:0]      wr_data,
	output logic [rsem_pkg::CHK_W-1:0]       wr_chk,
	// Read port
	output logic                             rd_clk,
	output logic                             rd_en,
	output logic [rsem_pkg::ADDR_W-1:0]      rd_addr
);
	initial
	begin
		wr_clk = 1'b0;
		wr_en = 1'b0;
		wr_addr = '0;
		wr_data = '0;
		wr_chk = '0;
		rd_clk = 1'b0;
		rd_en = 1'b0;
		rd_addr = '0;
	end

	// One pin clock pulse, two cycles high, pins held three cycles past the fall
	task automatic write_word(input logic [8:0] a, input logic [63:0] d, input logic [7:0] c);
		@(posedge clk);
		wr_en <= 1'b1;
		wr_addr <= a;
		wr_data <= d;
		wr_chk <= c;
		@(posedge clk);
		wr_clk <= 1'b1;
		repeat (2) @(posedge clk);
		wr_clk <= 1'b0;
		repeat (3) @(posedge clk);
		// Released lines show garbage, not the old word
		wr_en <= 1'b0;
		wr_addr <= ~a;
		wr_data <= ~d;
		wr_chk <= ~c;
	endtask

	task automatic read_word(input logic [8:0] a, input logic e);
		@(posedge clk);
		rd_en <= e;
		rd_addr <= a;
		@(posedge clk);
		rd_clk <= 1'b1;
		repeat (2) @(posedge clk);
		rd_clk <= 1'b0;
		repeat (3) @(posedge clk);
		rd_en <= 1'b0;
		rd_addr <= ~a;
	endtask
endmodule

//--- tb/rsem_top_test.sv
// Self-checking bench for the SECDED memory block
`timescale 1ns/1ps
module rsem_top_test;
	logic        core_clk, arst_n, psel, penable, pwrite, pready, pslverr, irq, re;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rv;
	logic        wr_clk, wr_en, rd_clk, rd_en, sflag, dflag;
	logic [8:0]  wr_addr, rd_addr;
	logic [63:0] wr_data, rd_data;
	logic [7:0]  wr_chk, chk_out, rd_chk;
	logic [71:0] w, masks [4];
	int          n_fail, cmp_count, i;
	localparam logic [63:0] DA = 64'h0123_4567_89AB_CDEF;
	localparam logic [63:0] DB = 64'hFEDC_0000_1234_A5A5;

	rsem_top dut (.CORE_CLK(core_clk), .ARST_N(arst_n), .PSEL(psel), .PENABLE(penable),
		.PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PREADY(pready), .PRDATA(prdata),
		.PSLVERR(pslverr), .WRITE_CLOCK(wr_clk), .WRITE_ENABLE(wr_en), .WRITE_ADDR(wr_addr),
		.WRITE_DATA_IN(wr_data), .WRITE_CHECK_IN(wr_chk), .CHECK_BITS_OUT(chk_out),
		.READ_CLOCK(rd_clk), .READ_ENABLE(rd_en), .READ_ADDR(rd_addr), .READ_DATA_OUT(rd_data),
		.READ_CHECK_OUT(rd_chk), .SINGLE_ERROR_FLAG(sflag), .DOUBLE_ERROR_FLAG(dflag), .IRQ(irq));
	rsem_user_model u_user (.clk(core_clk), .wr_clk(wr_clk), .wr_en(wr_en), .wr_addr(wr_addr),
		.wr_data(wr_data), .wr_chk(wr_chk), .rd_clk(rd_clk), .rd_en(rd_en), .rd_addr(rd_addr));

	initial
	begin
		core_clk = 1'b0;
		forever #50 core_clk = ~core_clk;
	end

	// Reference check bits: positions 3..71 skipping powers of two, then overall parity
	function automatic logic [7:0] ecc(input logic [63:0] d);
		logic [7:0] c;
		int         p;
		c = 8'h00;
		p = 3;
		for (int k = 0; k < 64; k++)
		begin
			while ((p & (p - 1)) == 0) p++;
			if (d[k])
				c[6:0] = c[6:0] ^ p[6:0];
			p++;
		end
		c[7] = ^{d, c[6:0]};
		return c;
	endfunction

	task automatic cmp(input string nm, input logic [71:0] e, input logic [71:0] g);
		cmp_count++;
		if (g !== e)
		begin
			$display("wrong value %s expected %h seen %h", nm, e, g);
			n_fail++;
		end
	endtask

	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
		int n;
		n = 0;
		@(posedge core_clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= wd;
		@(posedge core_clk);
		penable <= 1'b1;
		do
		begin
			@(posedge core_clk);
			n++;
		end
		while (pready !== 1'b1 && n < 16);
		cmp("apb answer", 72'h0, {71'h0, n == 16});
		rv = prdata;
		re = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic rreg(input logic [11:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		cmp("register", {40'h0, e}, {40'h0, rv});
	endtask

	task automatic rchk(input logic [8:0] a, input logic e, input logic [71:0] wd,
		input logic [1:0] f);
		u_user.read_word(a, e);
		cmp("read word", wd, {rd_chk, rd_data});
		cmp("flags", {70'h0, f}, {70'h0, dflag, sflag});
	endtask

	task automatic conclude();
		$display("comparisons %0d mismatches %0d", cmp_count, n_fail);
		if (n_fail == 0 && cmp_count > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	initial
	begin
		#500000;
		n_fail++;
		conclude();
	end

	initial
	begin
		arst_n = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = '0;
		pwdata = '0;
		n_fail = 0;
		cmp_count = 0;
		masks[0] = 72'h1;
		masks[1] = {8'h80, 64'h0};
		masks[2] = {8'h04, 64'h8000_0000_0000_0000};
		masks[3] = 72'hC00;
		repeat (2) @(posedge core_clk);
		arst_n <= 1'b1;
		repeat (3) @(posedge core_clk);
		rreg(rsem_pkg::CTRL_OFF, 32'h3);
		rreg(rsem_pkg::ENABLE_OFF, 32'h0);
		rreg(rsem_pkg::STATUS_OFF, 32'h0);
		apb(1'b0, 12'h020, 32'h0);
		cmp("unmapped error", 72'h1, {71'h0, re});
		$display("register test done");
		u_user.write_word(9'h005, DA, 8'h00);
		cmp("check bits", {64'h0, ecc(DA)}, {64'h0, chk_out});
		rchk(9'h005, 1'b1, {ecc(DA), DA}, 2'b00);
		$display("standard test done");
		apb(1'b1, rsem_pkg::CTRL_OFF, 32'h2);
		apb(1'b1, rsem_pkg::ENABLE_OFF, 32'h3);
		for (i = 0; i < 4; i++)
		begin
			rchk(9'h005, 1'b1, {ecc(DA), DA}, 2'b00);
			w = {rd_chk, rd_data} ^ masks[i];
			u_user.write_word(9'h009, w[63:0], w[71:64]);
			rchk(9'h009, 1'b1, i < 2 ? {ecc(DA), DA} : w, i < 2 ? 2'b01 : 2'b10);
		end
		rreg(rsem_pkg::STATUS_OFF, 32'h3);
		cmp("irq raised", 72'h1, {71'h0, irq});
		rreg(rsem_pkg::SECCNT_OFF, 32'h2);
		rreg(rsem_pkg::DEDCNT_OFF, 32'h2);
		rreg(rsem_pkg::EADDR_OFF, 32'h9);
		rchk(9'h005, 1'b1, {ecc(DA), DA}, 2'b00);
		apb(1'b1, rsem_pkg::CLEAR_OFF, 32'h1);
		rreg(rsem_pkg::STATUS_OFF, 32'h2);
		cmp("irq held", 72'h1, {71'h0, irq});
		apb(1'b1, rsem_pkg::ENABLE_OFF, 32'h1);
		rreg(rsem_pkg::ENABLE_OFF, 32'h1);
		cmp("irq masked", 72'h0, {71'h0, irq});
		apb(1'b1, rsem_pkg::CLEAR_OFF, 32'h2);
		rreg(rsem_pkg::STATUS_OFF, 32'h0);
		$display("injection test done");
		apb(1'b1, rsem_pkg::CTRL_OFF, 32'h1);
		rchk(9'h009, 1'b1, w, 2'b00);
		u_user.write_word(9'h007, DB, 8'hA5);
		cmp("check bits", {64'h0, ecc(DB)}, {64'h0, chk_out});
		rreg(rsem_pkg::LASTCHK_OFF, {24'h0, ecc(DB)});
		rchk(9'h007, 1'b1, {ecc(DB), DB}, 2'b00);
		$display("encode test done");
		apb(1'b1, rsem_pkg::CTRL_OFF, 32'h6);
		u_user.write_word(9'h009, DA ^ 64'h8, ecc(DA));
		cmp("check held", {64'h0, ecc(DB)}, {64'h0, chk_out});
		u_user.read_word(9'h005, 1'b1);
		rchk(9'h009, 1'b1, {ecc(DA), DA}, 2'b00);
		rchk(9'h009, 1'b0, {ecc(DA), DA}, 2'b01);
		$display("register mode test done");
		conclude();
	end
endmodule
